//--- rtl/fnc_blink.v
`timescale 1ns/1ps
`default_nettype none
`include "fnc_defs.vh"
// ==========================================
// Free running blink phase, toggles every half period
module fnc_blink #(
  parameter HALF_CYC = `FNC_BLINK_HALF_CYC
) (
  input wire clock,
  input wire rst,
  output reg phase_q
);
  reg [31:0] cnt_q;
  // Toggle phase when the half period has elapsed
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0000_0000;
      phase_q <= 1'b0;
    end else if (cnt_q >= HALF_CYC - 1) begin
      cnt_q <= 32'h0000_0000;
      phase_q <= ~phase_q;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end
endmodule // fnc_blink
`default_nettype wire

//--- rtl/fnc_defs.vh
`ifndef FNC_DEFS_VH
`define FNC_DEFS_VH
// ==========================================
// Register offsets (word index, byte address = index)
`define FNC_REG_CTRL 4'h0
`define FNC_REG_STORED 4'h1
`define FNC_REG_NETSTAT 4'h2
`define FNC_REG_ACTIVE 4'h3
`define FNC_REG_OBJWR 4'h4
`define FNC_REG_TXTCMD 4'h5
// ==========================================
// Network object addresses
`define FNC_OBJ_CLASS_DEV 8'h03
`define FNC_OBJ_ATTR_ADDR 8'h01
`define FNC_OBJ_ATTR_RATE 8'h02
`define FNC_OBJ_CLASS_NVM 8'h25
`define FNC_OBJ_ATTR_SAVE 8'h65
// ==========================================
// Limits and rate codes
`define FNC_ADDR_MAX 7'd63
`define FNC_RATE_MAX 4'd2
`define FNC_RATE_125 2'd0
`define FNC_RATE_250 2'd1
`define FNC_RATE_500 2'd2
`define FNC_TXT_125 10'd125
`define FNC_TXT_250 10'd250
`define FNC_TXT_500 10'd500
// ==========================================
// Reset values of stored configuration
`define FNC_RST_ADDR 6'd63
`define FNC_RST_RATE 2'd0
// ==========================================
// Timing: clock 40 MHz, blink half period 500 ms
`define FNC_CLK_HZ 40000000
`define FNC_BLINK_HALF_MS 500
`define FNC_BLINK_HALF_CYC ((`FNC_CLK_HZ / 1000) * `FNC_BLINK_HALF_MS)
// ==========================================
// Indicator codes
`define FNC_LED_OFF 2'd0
`define FNC_LED_GREEN 2'd1
`define FNC_LED_RED 2'd2
`endif

//--- rtl/fnc_node_cfg.v
`timescale 1ns/1ps
`default_nettype none
`include "fnc_defs.vh"
module fnc_node_cfg #(
  parameter BLINK_HALF_CYC = `FNC_BLINK_HALF_CYC
) (
  input wire clock,
  input wire rst,
  input wire [3:0] address_tens_switch,
  input wire [3:0] address_units_switch,
  input wire [3:0] rate_switch,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire nvm_valid,
  input wire [5:0] nvm_addr,
  input wire [1:0] nvm_rate,
  output reg nvm_save_q,
  output reg [5:0] nvm_save_addr_q,
  output reg [1:0] nvm_save_rate_q,
  output reg [5:0] node_address_q,
  output reg [1:0] rate_code_q,
  output reg cfg_valid_q,
  output reg led_green_q,
  output reg led_red_q
);
  // ==========================================
  // Synchronised switch inputs
  // Switch levels come from the front panel, so both stages come before any logic
  wire [3:0] tens_s;
  wire [3:0] units_s;
  wire [3:0] rate_s;
  wire blink;
  fnc_sync #(.WIDTH(12)) u_sync (
    .clock(clock),
    .rst(rst),
    .din({address_tens_switch, address_units_switch, rate_switch}),
    .dout({tens_s, units_s, rate_s})
  );
  // Blink phase runs free; both colours share it so they stay in step
  fnc_blink #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
    .clock(clock),
    .rst(rst),
    .phase_q(blink)
  );

  // ==========================================
  // Configuration state
  reg [5:0] stored_addr_q;
  reg [1:0] stored_rate_q;
  reg restart_q;
  reg [1:0] settle_q;
  // Link and fault state below is reported by the protocol engine over the register port, except the two refusal flags at the end
  reg online_q;
  reg dup_done_q;
  reg connected_q;
  reg allocated_q;
  reg clear_err_q;
  reg io_wait_q;
  reg dup_fault_q;
  reg bus_off_q;
  reg txt_bad_q;
  reg obj_bad_q;

  // Switch decode: tens times ten plus units, 7 bits covers 0..127, which holds the 0..99 of two decimal digits
  wire [6:0] sw_addr = {3'b000, tens_s} * 7'd10 + {3'b000, units_s};
  // A digit past nine is not a decimal setting, so it counts as out of range
  wire tens_ok = (tens_s <= 4'd9);
  wire units_ok = (units_s <= 4'd9);
  wire addr_sw_ok = tens_ok && units_ok && (sw_addr <= `FNC_ADDR_MAX);
  // Rate switch codes past two select the stored code instead
  wire rate_sw_ok = (rate_s <= `FNC_RATE_MAX);

  // Object write decode from the write data word
  // Class sits in the top byte, attribute below it, the value in the low ten bits
  wire [7:0] obj_class = reg_wdata[31:24];
  wire [7:0] obj_attr = reg_wdata[23:16];
  wire [9:0] obj_val = reg_wdata[9:0];
  wire obj_wr = reg_wr && (reg_addr == `FNC_REG_OBJWR);
  wire txt_wr = reg_wr && (reg_addr == `FNC_REG_TXTCMD);
  wire is_dev = (obj_class == `FNC_OBJ_CLASS_DEV);
  wire is_nvm = (obj_class == `FNC_OBJ_CLASS_NVM);
  wire attr_addr = (obj_attr == `FNC_OBJ_ATTR_ADDR);
  wire attr_rate = (obj_attr == `FNC_OBJ_ATTR_RATE);
  wire attr_save = (obj_attr == `FNC_OBJ_ATTR_SAVE);
  // Out-of-range values are refused whole rather than truncated into range
  wire addr_val_ok = (obj_val <= {3'h0, `FNC_ADDR_MAX});
  wire rate_val_ok = (obj_val <= {6'h00, `FNC_RATE_MAX});
  wire wr_addr = obj_wr && is_dev && attr_addr && addr_val_ok;
  wire wr_rate = obj_wr && is_dev && attr_rate && rate_val_ok;
  wire wr_save = obj_wr && is_nvm && attr_save;
  wire obj_hit = wr_addr || wr_rate || wr_save;

  // ==========================================
  // Control and status register write decodes
  wire ctrl_wr = reg_wr && (reg_addr == `FNC_REG_CTRL);
  wire restart_wr = ctrl_wr && reg_wdata[0];
  wire flag_clr = ctrl_wr && reg_wdata[1];
  wire netstat_wr = reg_wr && (reg_addr == `FNC_REG_NETSTAT);

  // Text command decode for the stored rate
  // Any other argument leaves the stored rate alone and raises the refusal flag
  reg txt_ok;
  reg [1:0] txt_code;
  always @* begin
    txt_ok = 1'b1;
    txt_code = `FNC_RATE_125;
    case (reg_wdata[9:0])
      `FNC_TXT_125: txt_code = `FNC_RATE_125;
      `FNC_TXT_250: txt_code = `FNC_RATE_250;
      `FNC_TXT_500: txt_code = `FNC_RATE_500;
      default: txt_ok = 1'b0;
    endcase
  end

  // ==========================================
  // Stored configuration, loaded from non-volatile memory
  // Writes here do not touch the active values until the next restart
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      stored_addr_q <= `FNC_RST_ADDR;
      stored_rate_q <= `FNC_RST_RATE;
    end else begin
      // Later writes in the same cycle win over the reload
      if (nvm_valid) begin
        // A stored code of three is not a rate, so it falls back to the default
        stored_addr_q <= nvm_addr;
        stored_rate_q <= (nvm_rate > 2'd2) ? `FNC_RST_RATE : nvm_rate;
      end
      if (wr_addr) begin
        stored_addr_q <= obj_val[5:0];
      end
      if (wr_rate) begin
        stored_rate_q <= obj_val[1:0];
      end
      if (txt_wr && txt_ok) begin
        stored_rate_q <= txt_code;
      end
    end
  end

  // ==========================================
  // Refusal flags: sticky until software clears them
  // Set wins over clear, so a refusal in the clearing cycle is not lost
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      txt_bad_q <= 1'b0;
      obj_bad_q <= 1'b0;
    end else begin
      if (txt_wr && !txt_ok) begin
        txt_bad_q <= 1'b1;
      end else if (flag_clr) begin
        txt_bad_q <= 1'b0;
      end
      if (obj_wr && !obj_hit) begin
        obj_bad_q <= 1'b1;
      end else if (flag_clr) begin
        obj_bad_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // Save pulse to the non-volatile store
  // The saved copy is taken from the stored values as they stand in that cycle
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      nvm_save_q <= 1'b0;
      nvm_save_addr_q <= `FNC_RST_ADDR;
      nvm_save_rate_q <= `FNC_RST_RATE;
    end else begin
      nvm_save_q <= wr_save;
      if (wr_save) begin
        nvm_save_addr_q <= stored_addr_q;
        nvm_save_rate_q <= stored_rate_q;
      end
    end
  end

  // ==========================================
  // Restart: waits for the synchronisers to settle, then latches once
  // Sampling only here keeps a bumped switch from moving a live node
  // A restart during the settle time starts the count over
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      restart_q <= 1'b1;
      settle_q <= 2'd0;
      cfg_valid_q <= 1'b0;
      node_address_q <= `FNC_RST_ADDR;
      rate_code_q <= `FNC_RST_RATE;
    end else if (restart_wr) begin
      restart_q <= 1'b1;
      settle_q <= 2'd0;
      cfg_valid_q <= 1'b0;
    end else if (restart_q) begin
      if (settle_q == 2'd3) begin
        restart_q <= 1'b0;
        cfg_valid_q <= 1'b1;
        // Each half falls back to the stored value on its own
        node_address_q <= addr_sw_ok ? sw_addr[5:0] : stored_addr_q;
        rate_code_q <= rate_sw_ok ? rate_s[1:0] : stored_rate_q;
      end else begin
        settle_q <= settle_q + 2'd1;
      end
    end
  end

  // ==========================================
  // Network status reported by the protocol engine
  // Restart drops the link state, so the green indicator goes dark until it is reported again
  // Error and fault bits survive a restart; only the link state is dropped
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      online_q <= 1'b0;
      dup_done_q <= 1'b0;
      connected_q <= 1'b0;
      allocated_q <= 1'b0;
      clear_err_q <= 1'b0;
      io_wait_q <= 1'b0;
      dup_fault_q <= 1'b0;
      bus_off_q <= 1'b0;
    end else if (restart_q) begin
      online_q <= 1'b0;
      dup_done_q <= 1'b0;
      connected_q <= 1'b0;
      allocated_q <= 1'b0;
    end else if (netstat_wr) begin
      online_q <= reg_wdata[0];
      dup_done_q <= reg_wdata[1];
      connected_q <= reg_wdata[2];
      allocated_q <= reg_wdata[3];
      clear_err_q <= reg_wdata[4];
      io_wait_q <= reg_wdata[5];
      dup_fault_q <= reg_wdata[6];
      bus_off_q <= reg_wdata[7];
    end
  end

  // ==========================================
  // Indicator priority: steady red, blinking red, off when not ready, green states
  // One wire per row of the indicator table, except blinking green, which is the final else
  wire cond_steady_red = dup_fault_q || bus_off_q;
  wire cond_blink_red = clear_err_q || io_wait_q;
  wire cond_not_ready = !online_q || !dup_done_q;
  wire cond_full_green = connected_q && allocated_q;
  reg [1:0] led_d;
  always @* begin
    if (cond_steady_red) begin
      led_d = `FNC_LED_RED;
    end else if (cond_blink_red) begin
      led_d = blink ? `FNC_LED_RED : `FNC_LED_OFF;
    end else if (cond_not_ready) begin
      led_d = `FNC_LED_OFF;
    end else if (cond_full_green) begin
      led_d = `FNC_LED_GREEN;
    end else begin
      led_d = blink ? `FNC_LED_GREEN : `FNC_LED_OFF;
    end
  end

  // Registered so the chain of priorities never glitches at the pins
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      led_green_q <= 1'b0;
      led_red_q <= 1'b0;
    end else begin
      led_green_q <= (led_d == `FNC_LED_GREEN);
      led_red_q <= (led_d == `FNC_LED_RED);
    end
  end

  // ==========================================
  // Register read, data one cycle after the strobe
  // Words are built apart from the mux so each field position reads plainly
  wire [31:0] ctrl_word = {
    28'h000_0000,
    obj_bad_q,
    txt_bad_q,
    cfg_valid_q,
    restart_q
  };
  wire [31:0] stored_word = {
    22'h00_0000,
    stored_rate_q,
    2'h0,
    stored_addr_q
  };
  wire [31:0] netstat_word = {
    24'h00_0000,
    bus_off_q,
    dup_fault_q,
    io_wait_q,
    clear_err_q,
    allocated_q,
    connected_q,
    dup_done_q,
    online_q
  };
  // Live switch levels sit beside the latched values for diagnosis only
  wire [31:0] active_word = {
    12'h000,
    rate_s,
    units_s,
    tens_s,
    rate_code_q,
    node_address_q
  };
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `FNC_REG_CTRL: reg_rdata <= ctrl_word;
        `FNC_REG_STORED: reg_rdata <= stored_word;
        `FNC_REG_NETSTAT: reg_rdata <= netstat_word;
        `FNC_REG_ACTIVE: reg_rdata <= active_word;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule // fnc_node_cfg
`default_nettype wire

//--- rtl/fnc_sync.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Two-stage synchroniser, one per bit
module fnc_sync #(
  parameter WIDTH = 4
) (
  input wire clock,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  genvar i;
  // First stage only feeds the second, to bound metastability
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= din[i];
          s2_q <= s1_q;
        end
      end
      assign dout[i] = s2_q;
    end
  endgenerate
endmodule // fnc_sync
`default_nettype wire

//--- sim/fnc_node_cfg_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Port checks on the configuration block
module fnc_node_cfg_monitor #(
  parameter BLINK_HALF_CYC = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic nvm_save_q,
  input wire logic [5:0] node_address_q,
  input wire logic [1:0] rate_code_q,
  input wire logic cfg_valid_q,
  input wire logic led_green_q,
  input wire logic led_red_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // The two steps of a change: save object write, then restart
  sequence save_wr;
    reg_wr && reg_addr == 4'h4 && reg_wdata[31:16] == 16'h2565;
  endsequence
  sequence restart_wr;
    reg_wr && reg_addr == 4'h0 && reg_wdata[0];
  endsequence
  save_pulse_a: assert property (save_wr |=> nvm_save_q ##1
    (nvm_save_q == $past(reg_wr && reg_addr == 4'h4 && reg_wdata[31:16] == 16'h2565)))
    else $error("save pulse wrong");
  save_cause_a: assert property (nvm_save_q |-> $past(reg_wr) && $past(reg_addr) == 4'h4)
    else $error("save without write");
  restart_drop_a: assert property (restart_wr |=> !cfg_valid_q)
    else $error("restart ignored");
  cfg_back_a: assert property ($fell(cfg_valid_q) |-> ##[1:12] cfg_valid_q)
    else $error("config not relatched");
  cfg_hold_a: assert property (cfg_valid_q && $past(cfg_valid_q) |->
    $stable(node_address_q) && $stable(rate_code_q))
    else $error("config moved while valid");
  rate_legal_a: assert property (rate_code_q != 2'h3)
    else $error("illegal rate code");
  led_excl_a: assert property (!(led_green_q && led_red_q))
    else $error("both colours lit");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside slot");
endmodule // fnc_node_cfg_monitor
bind fnc_node_cfg fnc_node_cfg_monitor #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_mon (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nvm_save_q(nvm_save_q),
  .node_address_q(node_address_q), .rate_code_q(rate_code_q), .cfg_valid_q(cfg_valid_q),
  .led_green_q(led_green_q), .led_red_q(led_red_q));
`default_nettype wire

//--- sim/fnc_node_cfg_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bench top
module fnc_node_cfg_tb_top;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [3:0] sw_tens = 4'h1, sw_units = 4'h0, sw_rate = 4'h1, reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, rd, reg_rdata;
  logic reg_wr = 1'h0, reg_rd = 1'h0, load = 1'h0;
  logic nvm_valid, nvm_save_q, cfg_valid_q, led_green_q, led_red_q;
  logic [5:0] nvm_addr, sv_addr, node_address_q;
  logic [1:0] nvm_rate, sv_rate, rate_code_q;
  int num_errors = 0, n_compared = 0, cyc = 0;
  // Short blink so both phases show within a few dozen cycles
  fnc_node_cfg #(.BLINK_HALF_CYC(4)) DUT (
    .clock(clock), .rst(rst), .address_tens_switch(sw_tens), .address_units_switch(sw_units),
    .rate_switch(sw_rate), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nvm_valid(nvm_valid), .nvm_addr(nvm_addr),
    .nvm_rate(nvm_rate), .nvm_save_q(nvm_save_q), .nvm_save_addr_q(sv_addr),
    .nvm_save_rate_q(sv_rate), .node_address_q(node_address_q), .rate_code_q(rate_code_q),
    .cfg_valid_q(cfg_valid_q), .led_green_q(led_green_q), .led_red_q(led_red_q));
  fnc_nvm_model NVM (.clock(clock), .rst(rst), .save(nvm_save_q), .save_addr(sv_addr),
    .save_rate(sv_rate), .load(load), .valid(nvm_valid), .addr(nvm_addr), .rate(nvm_rate));
  initial forever #12.5 clock = ~clock;
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [11:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clock);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 rd = reg_rdata;
  endtask
  task automatic wait_cfg;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 40 && cfg_valid_q !== 1'h1; i++) @(negedge clock);
    chk("cfg_valid", 12'h001, cfg_valid_q);
  endtask
  task automatic restart(input logic [3:0] t, u, r);
    @(posedge clock);
    sw_tens <= t;
    sw_units <= u;
    sw_rate <= r;
    wr(4'h0, 32'h0000_0001);
    wait_cfg();
  endtask
  task automatic t_switches;
    chk("node", 12'h00A, node_address_q);
    chk("rate", 12'h001, rate_code_q);
    for (int r = 0; r < 3; r++) begin
      restart(4'h6, 4'h3, 4'(r));
      chk("node", 12'h03F, node_address_q);
      chk("rate", 12'(r), rate_code_q);
    end
    @(posedge clock);
    sw_tens <= 4'h0;
    repeat (8) @(negedge clock);
    chk("node", 12'h03F, node_address_q);
  endtask
  task automatic t_stored;
    wr(4'h4, 32'h0301_0005);
    rd_reg(4'h1);
    chk("stored addr", 12'h005, rd[5:0]);
    chk("node", 12'h03F, node_address_q);
    wr(4'h4, 32'h2565_0000);
    repeat (2) @(negedge clock);
    chk("saved addr", 12'h005, sv_addr);
    wr(4'h4, 32'h0301_0007);
    @(posedge clock);
    load <= 1'h1;
    @(posedge clock);
    load <= 1'h0;
    rd_reg(4'h1);
    chk("reloaded addr", 12'h005, rd[5:0]);
    // Arguments 125, 250, 500 in turn
    for (int i = 0; i < 3; i++) begin
      wr(4'h5, 32'(125 << i));
      rd_reg(4'h1);
      chk("stored rate", 12'(i), rd[9:8]);
    end
    wr(4'h4, 32'h0302_0001);
    wr(4'h4, 32'h2565_0000);
    chk("rate", 12'h002, rate_code_q);
    @(negedge clock);
    chk("saved rate", 12'h001, sv_rate);
    restart(4'h6, 4'h4, 4'h3);
    chk("node", 12'h005, node_address_q);
    chk("rate", 12'h001, rate_code_q);
    rd_reg(4'h3);
    chk("active lo", 12'h645, rd[11:0]);
    chk("active hi", 12'h034, rd[23:12]);
  endtask
  task automatic t_refuse;
    wr(4'h5, 32'h0000_012C);
    wr(4'h4, 32'h0302_0003);
    rd_reg(4'h0);
    chk("flags", 12'h003, rd[3:2]);
    rd_reg(4'h1);
    chk("stored rate", 12'h001, rd[9:8]);
    wr(4'h0, 32'h0000_0002);
    rd_reg(4'h0);
    chk("flags", 12'h000, rd[3:2]);
    rd_reg(4'hE);
    chk("unmapped", 12'h000, rd[11:0]);
  endtask
  function automatic logic [1:0] cls(input int n);
    return n == 0 ? 2'h0 : n == 32 ? 2'h1 : 2'h2;
  endfunction
  // Expected class per colour: 0 off, 1 steady, 2 blinking
  task automatic led_case(input logic [7:0] ns, input logic [3:0] exp);
    int g = 0;
    int r = 0;
    wr(4'h2, {24'h00_0000, ns});
    repeat (4) @(negedge clock);
    repeat (32) begin
      @(negedge clock);
      g += led_green_q;
      r += led_red_q;
    end
    chk("led", exp, {cls(g), cls(r)});
  endtask
  task automatic t_led;
    led_case(8'h00, 4'h0);
    led_case(8'h0F, 4'h4);
    led_case(8'h03, 4'h8);
    led_case(8'h33, 4'h2);
    led_case(8'h23, 4'h2);
    led_case(8'h73, 4'h1);
    led_case(8'h83, 4'h1);
  endtask
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge clock);
    chk("reset node", 12'h03F, node_address_q);
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    wait_cfg();
    t_switches();
    t_stored();
    t_refuse();
    t_led();
    test_done();
  end
endmodule // fnc_node_cfg_tb_top
`default_nettype wire

//--- sim/fnc_nvm_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Non-volatile store behind the block
module fnc_nvm_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic save,
  input wire logic [5:0] save_addr,
  input wire logic [1:0] save_rate,
  input wire logic load,
  output logic valid,
  output logic [5:0] addr,
  output logic [1:0] rate
);
  logic [5:0] mem_addr_q;
  logic [1:0] mem_rate_q;
  // Keep what was saved, replay it for one cycle on load
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_addr_q <= 6'h3F;
      mem_rate_q <= 2'h0;
      valid <= 1'h0;
    end else begin
      valid <= load;
      if (save) begin
        mem_addr_q <= save_addr;
        mem_rate_q <= save_rate;
      end
    end
  end
  // Idle lines flip so a stale value is never mistaken for data
  assign addr = valid ? mem_addr_q : ~mem_addr_q;
  assign rate = valid ? mem_rate_q : ~mem_rate_q;
endmodule // fnc_nvm_model
`default_nettype wire
